//--- core/nvm_seq_pkg.sv
// Shared constants for the nonvolatile write/read sequencer.
// Assumes an APB slave with 32-bit data; byte address is four times the index.
package nvm_seq_pkg;

  localparam int          APB_AW       = 12;
  localparam int          IDX_W        = APB_AW - 2;
  // Register indices
  localparam [IDX_W-1:0]  IDX_DATA_LOW  = 10'h10C;
  localparam [IDX_W-1:0]  IDX_ADDR_LOW  = 10'h10D;
  localparam [IDX_W-1:0]  IDX_DATA_HIGH = 10'h10E;
  localparam [IDX_W-1:0]  IDX_ADDR_HIGH = 10'h10F;
  localparam [IDX_W-1:0]  IDX_CONTROL   = 10'h18C;
  localparam [IDX_W-1:0]  IDX_KEY_PORT  = 10'h18D;
  localparam [IDX_W-1:0]  IDX_STATUS    = 10'h190;

  // Widths of the implemented fields
  localparam int          ADDR_HI_W    = 5;
  localparam int          DATA_HI_W    = 6;
  localparam int          WORD_W       = 8 + DATA_HI_W;
  localparam int          MEM_AW       = 8 + ADDR_HI_W;

  // nvm_control bit positions
  localparam int          BIT_SPACE    = 7;
  localparam int          BIT_ABORT    = 3;
  localparam int          BIT_ARM      = 2;
  localparam int          BIT_WTRIG    = 1;
  localparam int          BIT_RTRIG    = 0;
  // Status register bit position
  localparam int          BIT_DONE     = 0;

  // Unlock keys
  localparam [7:0]        KEY_FIRST    = 8'h55;
  localparam [7:0]        KEY_SECOND   = 8'hAA;

  // Cycle counts (one pclk cycle is one instruction cycle)
  localparam [1:0]        FETCH_EE_CYC    = 2'h1;
  localparam [1:0]        FETCH_FLASH_CYC = 2'h2;
  localparam [1:0]        PREP_CYC        = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PREP  = 2'b01,
    ST_WRITE = 2'b11,
    ST_FETCH = 2'b10
  } seq_state_t;

  typedef enum logic [1:0] {
    UL_IDLE = 2'b00,
    UL_HALF = 2'b01,
    UL_OPEN = 2'b11
  } unlock_t;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_DLO, SEL_ALO, SEL_DHI, SEL_AHI, SEL_CTRL, SEL_KEY, SEL_STAT
  } reg_sel_t;

  function automatic reg_sel_t decode(input logic [APB_AW-1:0] addr);
    unique case (addr[APB_AW-1:2])
      IDX_DATA_LOW:  decode = SEL_DLO;
      IDX_ADDR_LOW:  decode = SEL_ALO;
      IDX_DATA_HIGH: decode = SEL_DHI;
      IDX_ADDR_HIGH: decode = SEL_AHI;
      IDX_CONTROL:   decode = SEL_CTRL;
      IDX_KEY_PORT:  decode = SEL_KEY;
      IDX_STATUS:    decode = SEL_STAT;
      default:       decode = SEL_NONE;
    endcase
  endfunction

endpackage

//--- core/nvm_write_timer.sv
// Write-cycle timer: counts one store from start, pulses at mid-point and end.
// Assumes start arrives only while idle; clear drops a cycle under way.
`timescale 1ns/100ps
module nvm_write_timer
  import nvm_seq_pkg::*;
#(
  parameter int CNT_W        = 16,
  parameter int WRITE_CYCLES = 1024
) (
  input  wire logic pclk,     // Clock
  input  wire logic presetn,  // Async reset, low
  input  wire logic clk_en,   // Freeze when low
  input  wire logic start,    // Begin a store cycle
  input  wire logic clear,    // Abandon the cycle
  output logic      half,     // Erase over, program now
  output logic      done      // Store cycle finished
);

  localparam [CNT_W-1:0] LAST = CNT_W'(WRITE_CYCLES - 1);
  localparam [CNT_W-1:0] MID  = CNT_W'(WRITE_CYCLES / 2);

  typedef struct packed {
    logic             run;
    logic [CNT_W-1:0] cnt;
    logic             half;
    logic             done;
  } tmr_t;

  tmr_t tmr_reg;
  tmr_t tmr_next;

  always_comb begin
    tmr_next      = tmr_reg;
    tmr_next.half = 1'b0;
    tmr_next.done = 1'b0;
    if (start) begin
      tmr_next.run = 1'b1;
      tmr_next.cnt = '0;
    end else if (tmr_reg.run) begin
      tmr_next.cnt  = tmr_reg.cnt + CNT_W'(1);
      tmr_next.half = (tmr_reg.cnt == MID);
      if (tmr_reg.cnt == LAST) begin
        tmr_next.run  = 1'b0;
        tmr_next.done = 1'b1;
      end
    end
    if (clear) begin
      tmr_next = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_reg <= '0;
    end else if (clk_en) begin
      tmr_reg <= tmr_next;
    end
  end

  assign half = tmr_reg.half;
  assign done = tmr_reg.done;

endmodule // nvm_write_timer

//--- core/nvm_write_read_sequencer.sv
// Data EEPROM / program flash access sequencer behind an APB register file.
// Assumes the memory answers mem_rdata in the same cycle while mem_read is high,
// and that core_reset is a one-cycle pulse from the same clock domain.
//
// Contract
// - Write trigger accepted only if arm bit was set by an earlier operation.
// - Clearing arm bit does not stop a write under way.
// - Keys 55h then AAh must precede the trigger to start a write.
// - EEPROM stores 8 bits of data low; flash stores 14 bits high:low.
// - Write completion clears trigger and sets the done flag.
// - Flash read delivers data two cycles after the fetch trigger.
// - Data registers hold fetched value until another read or firmware write.
// - Flash write halts instruction execution while the clock runs.
// - Peripherals keep running during the halt; their interrupts stay pending.
// - Two cycles after a flash trigger are used to prepare the write.
// - Execution resumes after the second preparation cycle once the write ends.
// - Flash writes are blocked while the store permit bit is clear.
// - No read-back or compare after a write.
// - EEPROM write erases then programs while the core keeps running.
// - Master or watchdog reset during a write sets the abort flag.
// - Trigger bits can be set by software, cleared only by hardware.
`timescale 1ns/100ps
module nvm_write_read_sequencer
  import nvm_seq_pkg::*;
#(
  parameter int CNT_W        = 16,
  parameter int WRITE_CYCLES = 1024
) (
  input  wire logic              pclk,               // Clock, 50 MHz
  input  wire logic              presetn,            // Power-on reset, low
  input  wire logic              clk_en,             // Freeze all state when low
  input  wire logic              core_reset,         // Master/watchdog reset pulse
  input  wire logic              flash_store_permit, // Configuration write permit
  input  wire logic              psel,               // APB select
  input  wire logic              penable,            // APB enable
  input  wire logic              pwrite,             // APB direction
  input  wire logic [APB_AW-1:0] paddr,              // APB byte address
  input  wire logic [31:0]       pwdata,             // APB write data
  output logic      [31:0]       prdata,             // APB read data
  output logic                   pready,             // APB ready
  output logic                   pslverr,            // APB error on unmapped
  input  wire logic [WORD_W-1:0] mem_rdata,          // Memory read word
  output logic      [MEM_AW-1:0] mem_addr,           // Memory address
  output logic      [WORD_W-1:0] mem_wdata,          // Memory write word
  output logic                   mem_space,          // 1 = program flash
  output logic                   mem_read,           // Read strobe, level
  output logic                   mem_erase,          // Erase pulse
  output logic                   mem_program,        // Program pulse
  output logic                   cpu_halt            // Stop instruction execution
);

  typedef struct packed {
    seq_state_t           st;
    logic [1:0]           cnt;
    unlock_t              unlock;
    logic                 space_select;
    logic                 store_abort_flag;
    logic                 store_arm;
    logic                 store_trigger;
    logic                 fetch_trigger;
    logic                 store_done_flag;
    logic [7:0]           addr_low;
    logic [ADDR_HI_W-1:0] addr_high;
    logic [7:0]           data_low;
    logic [DATA_HI_W-1:0] data_high;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    logic                 mem_read;
    logic                 mem_erase;
    logic                 mem_program;
    logic                 cpu_halt;
    logic                 tmr_start;
  } seq_t;

  seq_t       seq_reg;
  seq_t       seq_next;
  logic       tmr_half;
  logic       tmr_done;
  logic       acc;
  logic       wr_acc;
  reg_sel_t   sel;
  logic [1:0] fetch_len;
  logic       new_space;

  assign acc       = psel && penable && seq_reg.pready;
  assign wr_acc    = acc && pwrite;
  assign sel       = decode(paddr);
  assign fetch_len = seq_reg.space_select ? FETCH_FLASH_CYC : FETCH_EE_CYC;

  nvm_write_timer #(
    .CNT_W        (CNT_W),
    .WRITE_CYCLES (WRITE_CYCLES)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .start   (seq_reg.tmr_start),
    .clear   (core_reset),
    .half    (tmr_half),
    .done    (tmr_done)
  );

  always_comb begin
    seq_next             = seq_reg;
    seq_next.mem_erase   = 1'b0;
    seq_next.mem_program = 1'b0;
    seq_next.tmr_start   = 1'b0;
    // One wait state: ready rises in the second access cycle
    seq_next.pready      = psel && penable && !seq_reg.pready;
    seq_next.pslverr     = psel && penable && !seq_reg.pready && (sel == SEL_NONE);
    seq_next.prdata      = '0;
    new_space            = seq_reg.space_select;

    if (psel && penable && !seq_reg.pready && !pwrite) begin
      unique case (sel)
        SEL_DLO:  seq_next.prdata[7:0]           = seq_reg.data_low;
        SEL_ALO:  seq_next.prdata[7:0]           = seq_reg.addr_low;
        SEL_DHI:  seq_next.prdata[DATA_HI_W-1:0] = seq_reg.data_high;
        SEL_AHI:  seq_next.prdata[ADDR_HI_W-1:0] = seq_reg.addr_high;
        SEL_CTRL: begin
          seq_next.prdata[BIT_SPACE] = seq_reg.space_select;
          seq_next.prdata[BIT_ABORT] = seq_reg.store_abort_flag;
          seq_next.prdata[BIT_ARM]   = seq_reg.store_arm;
          seq_next.prdata[BIT_WTRIG] = seq_reg.store_trigger;
          seq_next.prdata[BIT_RTRIG] = seq_reg.fetch_trigger;
        end
        SEL_STAT: seq_next.prdata[BIT_DONE] = seq_reg.store_done_flag;
        SEL_KEY, SEL_NONE: seq_next.prdata = '0;
      endcase
    end

    if (acc) begin
      seq_next.unlock = UL_IDLE;
      if (wr_acc) begin
        unique case (sel)
          SEL_DLO: seq_next.data_low  = pwdata[7:0];
          SEL_ALO: seq_next.addr_low  = pwdata[7:0];
          SEL_DHI: seq_next.data_high = pwdata[DATA_HI_W-1:0];
          SEL_AHI: seq_next.addr_high = pwdata[ADDR_HI_W-1:0];
          SEL_STAT: seq_next.store_done_flag = pwdata[BIT_DONE];
          SEL_KEY: begin
            if (pwdata[7:0] == KEY_FIRST) begin
              seq_next.unlock = UL_HALF;
            end else if (pwdata[7:0] == KEY_SECOND && seq_reg.unlock == UL_HALF) begin
              seq_next.unlock = UL_OPEN;
            end
          end
          SEL_CTRL: begin
            // Space cannot move while an access is under way
            if (seq_reg.st == ST_IDLE && !seq_reg.store_trigger && !seq_reg.fetch_trigger) begin
              new_space             = pwdata[BIT_SPACE];
              seq_next.space_select = new_space;
            end
            seq_next.store_abort_flag = pwdata[BIT_ABORT];
            seq_next.store_arm        = pwdata[BIT_ARM];
            if (pwdata[BIT_WTRIG] && seq_reg.store_arm && seq_reg.unlock == UL_OPEN &&
                seq_reg.st == ST_IDLE && !seq_reg.store_trigger &&
                !seq_reg.fetch_trigger && (!new_space || flash_store_permit)) begin
              seq_next.store_trigger = 1'b1;
              seq_next.cnt           = '0;
              if (new_space) begin
                seq_next.st = ST_PREP;
              end else begin
                seq_next.st        = ST_WRITE;
                seq_next.mem_erase = 1'b1;
                seq_next.tmr_start = 1'b1;
              end
            end else if (pwdata[BIT_RTRIG] && seq_reg.st == ST_IDLE &&
                         !seq_reg.store_trigger && !seq_reg.fetch_trigger) begin
              seq_next.fetch_trigger = 1'b1;
              seq_next.cnt           = '0;
              seq_next.st            = ST_FETCH;
              seq_next.mem_read      = 1'b1;
            end
          end
          SEL_NONE: ;
        endcase
      end
    end

    unique case (seq_reg.st)
      ST_IDLE: ;
      ST_FETCH: begin
        if (seq_reg.cnt == fetch_len - 2'h1) begin
          seq_next.data_low      = mem_rdata[7:0];
          seq_next.data_high     = seq_reg.space_select ? mem_rdata[WORD_W-1:8] : '0;
          seq_next.fetch_trigger = 1'b0;
          seq_next.mem_read      = 1'b0;
          seq_next.st            = ST_IDLE;
        end else begin
          seq_next.cnt = seq_reg.cnt + 2'h1;
        end
      end
      ST_PREP: begin
        if (seq_reg.cnt == PREP_CYC - 2'h1) begin
          seq_next.st        = ST_WRITE;
          seq_next.cpu_halt  = 1'b1;
          seq_next.mem_erase = 1'b1;
          seq_next.tmr_start = 1'b1;
        end else begin
          seq_next.cnt = seq_reg.cnt + 2'h1;
        end
      end
      ST_WRITE: begin
        seq_next.mem_program = tmr_half;
        if (tmr_done) begin
          seq_next.store_trigger   = 1'b0;
          seq_next.store_done_flag = 1'b1;
          seq_next.cpu_halt        = 1'b0;
          seq_next.st              = ST_IDLE;
        end
      end
    endcase

    if (core_reset) begin
      if (seq_reg.st == ST_WRITE || seq_reg.st == ST_PREP) begin
        seq_next.store_abort_flag = 1'b1;
      end
      seq_next.st            = ST_IDLE;
      seq_next.unlock        = UL_IDLE;
      seq_next.store_arm     = 1'b0;
      seq_next.store_trigger = 1'b0;
      seq_next.fetch_trigger = 1'b0;
      seq_next.mem_read      = 1'b0;
      seq_next.mem_erase     = 1'b0;
      seq_next.mem_program   = 1'b0;
      seq_next.cpu_halt      = 1'b0;
      seq_next.tmr_start     = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= '0;
    end else if (clk_en) begin
      seq_reg <= seq_next;
    end
  end

  assign prdata      = seq_reg.prdata;
  assign pready      = seq_reg.pready;
  assign pslverr     = seq_reg.pslverr;
  assign mem_addr    = {seq_reg.addr_high, seq_reg.addr_low};
  assign mem_wdata   = {seq_reg.space_select ? seq_reg.data_high : {DATA_HI_W{1'b0}},
                        seq_reg.data_low};
  assign mem_space   = seq_reg.space_select;
  assign mem_read    = seq_reg.mem_read;
  assign mem_erase   = seq_reg.mem_erase;
  assign mem_program = seq_reg.mem_program;
  assign cpu_halt    = seq_reg.cpu_halt;

  logic ctrl_wr;
  assign ctrl_wr = wr_acc && sel == SEL_CTRL && !core_reset;

  property p_arm_first;
    @(posedge pclk iff clk_en) disable iff (!presetn)
    ctrl_wr && pwdata[BIT_WTRIG] && !seq_reg.store_arm && !seq_reg.store_trigger
      |=> !seq_reg.store_trigger;
  endproperty
  a_arm_first: assert property (p_arm_first) else $error("trigger taken without prior arm");

  property p_arm_clear;
    @(posedge pclk iff clk_en) disable iff (!presetn)
    ctrl_wr && !pwdata[BIT_ARM] && seq_reg.st == ST_WRITE && !tmr_done
      |=> seq_reg.store_trigger && seq_reg.st == ST_WRITE;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("arm clear stopped a write");

  property p_key;
    @(posedge pclk iff clk_en) disable iff (!presetn)
    $rose(seq_reg.store_trigger) |-> $past(seq_reg.unlock) == UL_OPEN;
  endproperty
  a_key: assert property (p_key) else $error("write started without keys");

  property p_done;
    @(posedge pclk iff clk_en) disable iff (!presetn || core_reset)
    seq_reg.st == ST_WRITE && tmr_done
      |=> !seq_reg.store_trigger && seq_reg.store_done_flag && !seq_reg.cpu_halt;
  endproperty
  a_done: assert property (p_done) else $error("completion not signalled");

  sequence s_flash_fetch;
    seq_reg.fetch_trigger ##1 seq_reg.fetch_trigger ##1 !seq_reg.fetch_trigger;
  endsequence
  property p_fetch;
    @(posedge pclk iff clk_en) disable iff (!presetn || core_reset)
    $rose(seq_reg.fetch_trigger) && seq_reg.space_select |-> s_flash_fetch;
  endproperty
  a_fetch: assert property (p_fetch) else $error("flash fetch not two cycles");

  property p_hold;
    @(posedge pclk iff clk_en) disable iff (!presetn)
    seq_reg.st == ST_IDLE && !wr_acc |=> $stable(seq_reg.data_low) && $stable(seq_reg.data_high);
  endproperty
  a_hold: assert property (p_hold) else $error("data registers changed");

  sequence s_prep_then_halt;
    !seq_reg.cpu_halt [*2] ##1 seq_reg.cpu_halt;
  endsequence
  property p_halt;
    @(posedge pclk iff clk_en) disable iff (!presetn || core_reset)
    $rose(seq_reg.store_trigger) && seq_reg.space_select |-> s_prep_then_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("flash halt timing wrong");

  property p_permit;
    @(posedge pclk iff clk_en) disable iff (!presetn)
    ctrl_wr && !flash_store_permit && !seq_reg.store_trigger &&
      (pwdata[BIT_SPACE] || seq_reg.space_select) && seq_reg.st == ST_IDLE
      |=> !seq_reg.store_trigger || !seq_reg.space_select;
  endproperty
  a_permit: assert property (p_permit) else $error("flash write without permit");

  property p_abort;
    @(posedge pclk iff clk_en) disable iff (!presetn)
    core_reset && seq_reg.st == ST_WRITE |=> seq_reg.store_abort_flag && !seq_reg.store_trigger;
  endproperty
  a_abort: assert property (p_abort) else $error("abort flag not set");

  // The reset pulse is a sampled term here: as a disable it is already low when checked
  property p_sw_no_clear;
    @(posedge pclk iff clk_en) disable iff (!presetn)
    seq_reg.store_trigger && !tmr_done && !core_reset |=> seq_reg.store_trigger;
  endproperty
  a_sw_no_clear: assert property (p_sw_no_clear) else $error("trigger cleared early");

endmodule // nvm_write_read_sequencer

//--- bench/nvm_mem_model.sv
// Behavioural memory seen by the sequencer: data and program space in one array.
// Assumes same-cycle reads while mem_read is high and strobes from the pclk domain.
`timescale 1ns/100ps
module nvm_mem_model
  import nvm_seq_pkg::*;
(
  input  wire logic              pclk,        // Clock
  input  wire logic [MEM_AW-1:0] mem_addr,    // Word address
  input  wire logic [WORD_W-1:0] mem_wdata,   // Word to program
  input  wire logic              mem_space,   // 1 = program flash
  input  wire logic              mem_read,    // Read strobe
  input  wire logic              mem_erase,   // Erase pulse
  input  wire logic              mem_program, // Program pulse
  output logic      [WORD_W-1:0] mem_rdata    // Read word
);
  logic [WORD_W-1:0] m [0:2**(MEM_AW+1)-1];
  wire  [MEM_AW:0]   idx = {mem_space, mem_addr};

  initial for (int i = 0; i < 2**(MEM_AW+1); i++) m[i] = i[WORD_W-1:0];
  // Outside a read the bus shows the inverse, so a stale capture cannot pass
  assign mem_rdata = mem_read ? m[idx] : ~m[idx];
  always @(posedge pclk) begin
    if (mem_erase) m[idx] <= '1;
    else if (mem_program) m[idx] <= mem_wdata;
  end
endmodule // nvm_mem_model

//--- bench/tb_top.sv
// Self-checking bench: APB register sequences against the sequencer and a memory model.
// Assumes the design's one-wait-state APB slave and a write cycle of WC pclk cycles.
`timescale 1ns/100ps
module tb_top;
  import nvm_seq_pkg::*;
  localparam int WC = 16;
  logic              pclk = 0, presetn = 0, core_reset = 0, permit = 0;
  logic              psel = 0, penable = 0, pwrite = 0, pready, pslverr, halt_seen = 0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, v;
  logic [MEM_AW-1:0] mem_addr;
  logic [WORD_W-1:0] mem_rdata, mem_wdata;
  logic              mem_space, mem_read, mem_erase, mem_program, cpu_halt, err;
  int                mismatches = 0, num_checks = 0, cyc = 0;

  always #10 pclk = ~pclk;

  nvm_write_read_sequencer #(.WRITE_CYCLES(WC)) i_dut (.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .core_reset(core_reset), .flash_store_permit(permit), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_space(mem_space), .mem_read(mem_read),
    .mem_erase(mem_erase), .mem_program(mem_program), .cpu_halt(cpu_halt));
  nvm_mem_model i_mem (.pclk(pclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_space(mem_space), .mem_read(mem_read), .mem_erase(mem_erase),
    .mem_program(mem_program), .mem_rdata(mem_rdata));

  always @(posedge pclk) begin
    if (cpu_halt === 1'b1) halt_seen <= 1'b1;
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, exp, got);
    end
  endtask

  // One APB transfer; starts at the next edge so signals never change twice in a step
  task automatic apb(input logic w, input logic [IDX_W-1:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    v = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d); apb(1'b1, i, d); endtask
  task automatic rd(input logic [IDX_W-1:0] i); apb(1'b0, i, 32'h0); endtask

  task automatic unlock_go(input logic [31:0] c);
    wr(IDX_KEY_PORT, 32'(KEY_FIRST));
    wr(IDX_KEY_PORT, 32'(KEY_SECOND));
    wr(IDX_CONTROL, c);
  endtask

  // poll before reuse
  // Poll the store trigger, as firmware would, with a bounded count
  task automatic wait_done();
    for (int k = 0; k < 40; k++) begin
      rd(IDX_CONTROL);
      if (v[1] === 1'b0) break;
    end
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_CONTROL); chk("control_reset", v, 32'h0);
    rd(IDX_STATUS); chk("status_reset", v, 32'h0);
    rd(10'h000); chk("unmapped_err", 32'(err), 32'h1); chk("unmapped_data", v, 32'h0);
    $display("test reset done");
    wr(IDX_DATA_LOW, 32'h5A); wr(IDX_ADDR_LOW, 32'h03); wr(IDX_DATA_HIGH, 32'h3F);
    wr(IDX_CONTROL, 32'h00);
    unlock_go(32'h06);
    rd(IDX_CONTROL); chk("arm_same_write", v, 32'h04);
    wr(IDX_KEY_PORT, 32'h55); rd(IDX_STATUS); wr(IDX_KEY_PORT, 32'hAA);
    wr(IDX_CONTROL, 32'h06);
    rd(IDX_CONTROL); chk("broken_unlock", v, 32'h04);
    $display("test refusals done");
    unlock_go(32'h06);
    rd(IDX_CONTROL); chk("ee_started", v, 32'h06);
    wr(IDX_CONTROL, 32'h00);
    rd(IDX_CONTROL); chk("trigger_kept", v, 32'h02);
    wait_done();
    chk("ee_word", 32'(i_mem.m[14'h0003]), 32'h5A);
    chk("ee_no_halt", 32'(halt_seen), 32'h0);
    rd(IDX_STATUS); chk("done_flag", v, 32'h1);
    wr(IDX_STATUS, 32'h0);
    rd(IDX_STATUS); chk("done_cleared", v, 32'h0);
    $display("test eeprom store done");
    wr(IDX_ADDR_LOW, 32'h21); wr(IDX_ADDR_HIGH, 32'h12);
    wr(IDX_DATA_LOW, 32'hA5); wr(IDX_DATA_HIGH, 32'h2B); wr(IDX_CONTROL, 32'h84);
    unlock_go(32'h86);
    rd(IDX_CONTROL); chk("flash_blocked", v, 32'h84);
    permit <= 1'b1;
    unlock_go(32'h86);
    rd(IDX_CONTROL); chk("flash_busy", v, 32'h86);
    chk("halt_held", 32'(cpu_halt), 32'h1);
    wait_done();
    chk("halt_seen", 32'(halt_seen), 32'h1);
    chk("halt_released", 32'(cpu_halt), 32'h0);
    chk("flash_word", 32'(i_mem.m[14'h3221]), 32'h2BA5);
    wr(IDX_CONTROL, 32'h86);
    rd(IDX_CONTROL); chk("one_unlock_one_write", v, 32'h84);
    $display("test flash store done");
    wr(IDX_DATA_LOW, 32'h0); wr(IDX_DATA_HIGH, 32'h0); wr(IDX_CONTROL, 32'h81);
    rd(IDX_DATA_LOW); chk("fetch_low", v, 32'hA5);
    rd(IDX_DATA_HIGH); chk("fetch_high", v, 32'h2B);
    wr(IDX_ADDR_LOW, 32'h03);
    rd(IDX_DATA_LOW); chk("fetch_held", v, 32'hA5);
    wr(IDX_ADDR_HIGH, 32'h0); wr(IDX_CONTROL, 32'h01);
    rd(IDX_DATA_LOW); chk("ee_fetch_low", v, 32'h5A);
    rd(IDX_DATA_HIGH); chk("ee_fetch_high", v, 32'h0);
    $display("test fetch done");
    wr(IDX_CONTROL, 32'h04);
    unlock_go(32'h06);
    core_reset <= 1'b1;
    @(posedge pclk);
    core_reset <= 1'b0;
    rd(IDX_CONTROL); chk("abort_flag", v, 32'h08);
    $display("test abort done");
    final_report();
  end
endmodule // tb_top
